/* design/eprm_host.sv */
// eprm_host: controller driving a one-time-programmable memory's pins
//
// Notes on behaviour
// R01: the device holds 256K bytes on 18 address and 8 shared data lines.
// R02: blank cells read as ones; programming only clears bits.
// R03: the whole byte is driven on all eight data lines while programming.
// R04: raise programming supply with strobe high before any program pulse.
// R05: one 10 us low strobe pulse, only after address and data settle.
// R06: on verify mismatch pulse again, at most 25 pulses, then report failure.
// R07: software steps every address, then re-verifies at normal supply.
// R08: raised supply, strobe low, select low programs the addressed byte.
// R09: raised supply with select high inhibits programming, outputs float.
// R10: parallel devices share lines but each gets its own select and gate.
// R11: program verify uses select and gate low, strobe high, supply raised.
// R12: high voltage on line 9 makes the device output its identifier bytes.
// R13: during identification all address lines but 0 and 9 are held low.
// R14: identifier bytes carry odd parity, top bit being the parity bit.
// R15: array data is driven only while select and gate are both low.
// R16: gate high with select low leaves the outputs floating.
// R17: data follows gate fall after gate delay, given select and address early.
// R18: select high means standby with floating outputs.
// R19: select is the per-device choice; gate acts as the read strobe.
// R20: supply and identify voltages are plain digital qualifier levels.
//
// Design decisions made here: the AXI4-Lite interface to the registers and the register offsets.
module eprm_host
	import eprm_pkg::*;
(
	input  wire logic                   clk,
	input  wire logic                   rst,
	input  wire logic [EPRM_BUS_AW-1:0] s_axi_awaddr,
	input  wire logic                   s_axi_awvalid,
	output logic                        s_axi_awready,
	input  wire logic [31:0]            s_axi_wdata,
	input  wire logic [3:0]             s_axi_wstrb,
	input  wire logic                   s_axi_wvalid,
	output logic                        s_axi_wready,
	output logic [1:0]                  s_axi_bresp,
	output logic                        s_axi_bvalid,
	input  wire logic                   s_axi_bready,
	input  wire logic [EPRM_BUS_AW-1:0] s_axi_araddr,
	input  wire logic                   s_axi_arvalid,
	output logic                        s_axi_arready,
	output logic [31:0]                 s_axi_rdata,
	output logic [1:0]                  s_axi_rresp,
	output logic                        s_axi_rvalid,
	input  wire logic                   s_axi_rready,
	output logic [EPRM_AW-1:0]          address_lines,
	output logic [EPRM_DW-1:0]          data_lines_out,
	output logic                        data_lines_oe,
	input  wire logic [EPRM_DW-1:0]     data_lines_in,
	output logic                        chip_select_low,
	output logic                        output_gate_low,
	output logic                        program_strobe_low,
	output logic                        program_supply_high,
	output logic                        identify_high_voltage
);
	typedef enum logic [3:0] {
		ST_IDLE,
		ST_SUPPLY,
		ST_SETUP,
		ST_PULSE,
		ST_HOLD,
		ST_SELECT,
		ST_GATE,
		ST_CHECK,
		ST_RELEASE
	} eprm_state_type;

	eprm_cmd_if cmd ();

	eprm_state_type       state_r, state_nxt;
	logic [9:0]           timer_r, timer_nxt;
	eprm_op_type          op_r;
	logic [EPRM_DW-1:0]   target_r;
	logic [4:0]           pulses_r, pulses_nxt;
	logic                 fail_r, fail_nxt;
	logic                 done_r, done_nxt;
	logic [EPRM_DW-1:0]   rdata_r, rdata_nxt;
	logic [EPRM_AW-1:0]   addr_nxt;
	logic [EPRM_DW-1:0]   dout_nxt;
	logic                 doe_nxt, cs_nxt, gate_nxt, strobe_nxt;
	logic                 supply_nxt, ident_nxt;
	logic                 expired;
	logic                 cs_act_r, gate_act_r, strobe_act_r;

	eprm_axil_regs u_regs (
		.clk           (clk),
		.rst           (rst),
		.cmd           (cmd.bank),
		.s_axi_awaddr  (s_axi_awaddr),
		.s_axi_awvalid (s_axi_awvalid),
		.s_axi_awready (s_axi_awready),
		.s_axi_wdata   (s_axi_wdata),
		.s_axi_wstrb   (s_axi_wstrb),
		.s_axi_wvalid  (s_axi_wvalid),
		.s_axi_wready  (s_axi_wready),
		.s_axi_bresp   (s_axi_bresp),
		.s_axi_bvalid  (s_axi_bvalid),
		.s_axi_bready  (s_axi_bready),
		.s_axi_araddr  (s_axi_araddr),
		.s_axi_arvalid (s_axi_arvalid),
		.s_axi_arready (s_axi_arready),
		.s_axi_rdata   (s_axi_rdata),
		.s_axi_rresp   (s_axi_rresp),
		.s_axi_rvalid  (s_axi_rvalid),
		.s_axi_rready  (s_axi_rready)
	);

	assign cmd.busy   = (state_r != ST_IDLE);
	assign cmd.done   = done_r;
	assign cmd.fail   = fail_r;
	assign cmd.rdata  = rdata_r;
	assign cmd.pulses = pulses_r;
	assign expired    = (timer_r == 10'h000);

	always_comb begin
		state_nxt  = state_r;
		timer_nxt  = expired ? timer_r : timer_r - 10'h001;
		pulses_nxt = pulses_r;
		fail_nxt   = fail_r;
		done_nxt   = 1'b0;
		rdata_nxt  = rdata_r;
		addr_nxt   = address_lines;
		dout_nxt   = data_lines_out;
		doe_nxt    = data_lines_oe;
		cs_nxt     = cs_act_r;
		gate_nxt   = gate_act_r;
		strobe_nxt = strobe_act_r;
		supply_nxt = program_supply_high;
		ident_nxt  = identify_high_voltage;
		case (state_r)
			ST_IDLE: begin
				if (cmd.start) begin
					pulses_nxt = 5'h00;
					fail_nxt   = 1'b0;
					addr_nxt   = cmd.addr; // [R01]
					if (cmd.op == EPRM_OP_PROGRAM ||
						cmd.op == EPRM_OP_VERIFY) begin
						// strobe stays high as supply rises [R04] [R20]
						supply_nxt = 1'b1;
						state_nxt  = ST_SUPPLY;
						timer_nxt  = EPRM_SETUP_CYC;
					end else begin // normal supply, final sweep [R07]
						if (cmd.op == EPRM_OP_IDENT) begin
							// only line 0 may vary here [R13] [R12]
							addr_nxt  = {{(EPRM_AW-1){1'b0}}, cmd.addr[0]};
							ident_nxt = 1'b1;
						end
						cs_nxt    = 1'b1; // select first, gate later [R19]
						state_nxt = ST_SELECT;
						timer_nxt = EPRM_ACCESS_CYC - EPRM_GATE_CYC; // [R17]
					end
				end
			end
			ST_SUPPLY: begin
				if (expired) begin
					cs_nxt = 1'b1; // own select per device [R10]
					if (op_r == EPRM_OP_VERIFY) begin
						state_nxt = ST_SELECT;
						timer_nxt = EPRM_SETUP_CYC;
					end else begin
						dout_nxt  = target_r; // full byte in parallel [R03]
						doe_nxt   = 1'b1;
						state_nxt = ST_SETUP;
						timer_nxt = EPRM_SETUP_CYC;
					end
				end
			end
			ST_SETUP: begin
				// gate held high so the device does not fight our data
				if (expired) begin
					strobe_nxt = 1'b1; // pulse after settling [R05] [R08]
					pulses_nxt = pulses_r + 5'h01;
					state_nxt  = ST_PULSE;
					// a state lasts its count plus one cycle
					timer_nxt  = EPRM_PULSE_CYC - 10'h001;
				end
			end
			ST_PULSE: begin
				if (expired) begin
					strobe_nxt = 1'b0;
					state_nxt  = ST_HOLD;
					timer_nxt  = EPRM_SETUP_CYC;
				end
			end
			ST_HOLD: begin
				if (expired) begin
					doe_nxt   = 1'b0;
					state_nxt = ST_SELECT;
					timer_nxt = EPRM_SETUP_CYC;
				end
			end
			ST_SELECT: begin
				if (expired) begin
					gate_nxt  = 1'b1; // verify: both low, strobe high [R11]
					state_nxt = ST_GATE;
					timer_nxt = EPRM_GATE_CYC; // [R17]
				end
			end
			ST_GATE: begin
				if (expired) begin
					rdata_nxt = data_lines_in; // driven only now [R15]
					state_nxt = (op_r == EPRM_OP_PROGRAM) ? ST_CHECK
						: ST_RELEASE;
					if (op_r != EPRM_OP_PROGRAM) begin
						gate_nxt  = 1'b0;
						timer_nxt = EPRM_FLOAT_CYC;
					end
				end
			end
			ST_CHECK: begin
				gate_nxt = 1'b0; // outputs float before we drive [R16]
				if (rdata_r == target_r) begin
					state_nxt = ST_RELEASE;
					timer_nxt = EPRM_FLOAT_CYC;
				end else if (pulses_r >= EPRM_MAX_PULSES) begin // [R06]
					fail_nxt  = 1'b1;
					state_nxt = ST_RELEASE;
					timer_nxt = EPRM_FLOAT_CYC;
				end else begin
					// wait out the float time, then pulse again [R06]
					state_nxt = ST_SUPPLY;
					timer_nxt = EPRM_FLOAT_CYC;
				end
			end
			ST_RELEASE: begin
				if (expired) begin
					cs_nxt     = 1'b0; // back to standby [R18] [R09]
					supply_nxt = 1'b0;
					ident_nxt  = 1'b0;
					done_nxt   = 1'b1;
					state_nxt  = ST_IDLE;
				end
			end
			default: state_nxt = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_r <= ST_IDLE;
			timer_r <= 10'h000;
		end else begin
			state_r <= state_nxt;
			timer_r <= timer_nxt;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			op_r     <= EPRM_OP_READ;
			target_r <= 8'hFF;
		end else if (state_r == ST_IDLE && cmd.start) begin
			op_r     <= cmd.op;
			target_r <= cmd.wdata;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			pulses_r <= 5'h00;
			fail_r   <= 1'b0;
			done_r   <= 1'b0;
			rdata_r  <= 8'hFF;
		end else begin
			pulses_r <= pulses_nxt;
			fail_r   <= fail_nxt;
			done_r   <= done_nxt;
			rdata_r  <= rdata_nxt;
		end
	end

	// pins: the *_low outputs are kept as "asserted" flags and
	// inverted below so the pins sit high (inactive) after reset
	always_ff @(posedge clk) begin
		if (rst) begin
			address_lines       <= '0;
			data_lines_out      <= 8'hFF;
			data_lines_oe       <= 1'b0;
			program_supply_high <= 1'b0;
			identify_high_voltage <= 1'b0;
		end else begin
			address_lines       <= addr_nxt;
			data_lines_out      <= dout_nxt;
			data_lines_oe       <= doe_nxt;
			program_supply_high <= supply_nxt;
			identify_high_voltage <= ident_nxt;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			cs_act_r     <= 1'b0;
			gate_act_r   <= 1'b0;
			strobe_act_r <= 1'b0;
		end else begin
			cs_act_r     <= cs_nxt;
			gate_act_r   <= gate_nxt;
			strobe_act_r <= strobe_nxt;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			chip_select_low    <= 1'b1;
			output_gate_low    <= 1'b1;
			program_strobe_low <= 1'b1;
		end else begin
			chip_select_low    <= !cs_nxt;
			output_gate_low    <= !gate_nxt;
			program_strobe_low <= !strobe_nxt;
		end
	end
endmodule // eprm_host

/* design/eprm_pkg.sv */
// eprm_pkg: constants shared by the one-time-programmable memory controller
package eprm_pkg;
	localparam int          EPRM_AW       = 18;
	localparam int          EPRM_DW       = 8;
	localparam int          EPRM_BUS_AW   = 8;
	localparam logic [4:0]  EPRM_MAX_PULSES = 5'h19;

	// register map, byte addresses
	localparam logic [7:0]  EPRM_OFS_CTRL   = 8'h00;
	localparam logic [7:0]  EPRM_OFS_ADDR   = 8'h04;
	localparam logic [7:0]  EPRM_OFS_WDATA  = 8'h08;
	localparam logic [7:0]  EPRM_OFS_STATUS = 8'h0C;
	localparam logic [7:0]  EPRM_OFS_RDATA  = 8'h10;

	// field positions
	localparam int          EPRM_CTRL_START   = 0;
	localparam int          EPRM_CTRL_OP_LO   = 1;
	localparam int          EPRM_ST_BUSY      = 0;
	localparam int          EPRM_ST_DONE      = 1;
	localparam int          EPRM_ST_FAIL      = 2;
	localparam int          EPRM_ST_PULSES_LO = 8;

	localparam logic [1:0]  EPRM_RESP_OKAY   = 2'h0;
	localparam logic [1:0]  EPRM_RESP_SLVERR = 2'h2;
	localparam logic [31:0] EPRM_WORD_ZERO   = 32'h0000_0000;

	typedef enum logic [1:0] {
		EPRM_OP_READ,
		EPRM_OP_PROGRAM,
		EPRM_OP_IDENT,
		EPRM_OP_VERIFY
	} eprm_op_type;

	// timing, in ns, then cycles at the clock rate
	localparam int          EPRM_CLK_MHZ   = 100;
	localparam int          EPRM_PULSE_NS  = 10000;
	localparam int          EPRM_SETUP_NS  = 2000;
	localparam int          EPRM_ACCESS_NS = 150;
	localparam int          EPRM_GATE_NS   = 65;
	localparam int          EPRM_FLOAT_NS  = 130;
	localparam logic [9:0]  EPRM_PULSE_CYC  =
		10'((EPRM_PULSE_NS * EPRM_CLK_MHZ + 999) / 1000);
	localparam logic [9:0]  EPRM_SETUP_CYC  =
		10'((EPRM_SETUP_NS * EPRM_CLK_MHZ + 999) / 1000);
	localparam logic [9:0]  EPRM_ACCESS_CYC =
		10'((EPRM_ACCESS_NS * EPRM_CLK_MHZ + 999) / 1000);
	localparam logic [9:0]  EPRM_GATE_CYC   =
		10'((EPRM_GATE_NS * EPRM_CLK_MHZ + 999) / 1000);
	localparam logic [9:0]  EPRM_FLOAT_CYC  =
		10'((EPRM_FLOAT_NS * EPRM_CLK_MHZ + 999) / 1000);
endpackage : eprm_pkg

/* design/eprm_cmd_if.sv */
// eprm_cmd_if: command and result lines between register bank and sequencer
interface eprm_cmd_if;
	import eprm_pkg::*;
	logic                 start;
	eprm_op_type          op;
	logic [EPRM_AW-1:0]   addr;
	logic [EPRM_DW-1:0]   wdata;
	logic                 busy;
	logic                 done;
	logic                 fail;
	logic [EPRM_DW-1:0]   rdata;
	logic [4:0]           pulses;

	modport bank (output start, op, addr, wdata,
		input busy, done, fail, rdata, pulses);
	modport seq (input start, op, addr, wdata,
		output busy, done, fail, rdata, pulses);
endinterface : eprm_cmd_if

/* design/eprm_axil_regs.sv */
// eprm_axil_regs: AXI4-Lite register bank of the memory controller
module eprm_axil_regs
	import eprm_pkg::*;
(
	input  wire logic                   clk,
	input  wire logic                   rst,
	eprm_cmd_if.bank                    cmd,
	input  wire logic [EPRM_BUS_AW-1:0] s_axi_awaddr,
	input  wire logic                   s_axi_awvalid,
	output logic                        s_axi_awready,
	input  wire logic [31:0]            s_axi_wdata,
	input  wire logic [3:0]             s_axi_wstrb,
	input  wire logic                   s_axi_wvalid,
	output logic                        s_axi_wready,
	output logic [1:0]                  s_axi_bresp,
	output logic                        s_axi_bvalid,
	input  wire logic                   s_axi_bready,
	input  wire logic [EPRM_BUS_AW-1:0] s_axi_araddr,
	input  wire logic                   s_axi_arvalid,
	output logic                        s_axi_arready,
	output logic [31:0]                 s_axi_rdata,
	output logic [1:0]                  s_axi_rresp,
	output logic                        s_axi_rvalid,
	input  wire logic                   s_axi_rready
);
	logic                   aw_held_r;
	logic                   w_held_r;
	logic [EPRM_BUS_AW-1:0] awaddr_r;
	logic [31:0]            wdata_r;
	logic [3:0]             wstrb_r;
	logic [31:0]            addr_reg_r;
	logic [31:0]            wdata_reg_r;
	logic                   done_r;
	logic                   start_r;
	eprm_op_type            op_r;
	logic                   wr_go;
	logic [31:0]            status;
	logic [31:0]            rd_word;
	logic                   rd_hit;

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++)
			if (strb[i])
				res[i*8 +: 8] = nw[i*8 +: 8];
		return res;
	endfunction

	assign wr_go = aw_held_r && w_held_r && !s_axi_bvalid;
	assign s_axi_awready = !aw_held_r;
	assign s_axi_wready  = !w_held_r;

	always_ff @(posedge clk) begin
		if (rst) begin
			aw_held_r <= 1'b0;
			w_held_r  <= 1'b0;
			awaddr_r  <= '0;
			wdata_r   <= EPRM_WORD_ZERO;
			wstrb_r   <= 4'h0;
		end else begin
			if (s_axi_awvalid && !aw_held_r) begin
				aw_held_r <= 1'b1;
				awaddr_r  <= s_axi_awaddr;
			end else if (wr_go) begin
				aw_held_r <= 1'b0;
			end
			if (s_axi_wvalid && !w_held_r) begin
				w_held_r <= 1'b1;
				wdata_r  <= s_axi_wdata;
				wstrb_r  <= s_axi_wstrb;
			end else if (wr_go) begin
				w_held_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= EPRM_RESP_OKAY;
		end else if (wr_go) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= (awaddr_r == EPRM_OFS_CTRL ||
				awaddr_r == EPRM_OFS_ADDR || awaddr_r == EPRM_OFS_WDATA ||
				awaddr_r == EPRM_OFS_STATUS) ? EPRM_RESP_OKAY
				: EPRM_RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			addr_reg_r  <= EPRM_WORD_ZERO;
			wdata_reg_r <= EPRM_WORD_ZERO;
			start_r     <= 1'b0;
			op_r        <= EPRM_OP_READ;
		end else begin
			start_r <= 1'b0;
			if (wr_go && awaddr_r == EPRM_OFS_ADDR)
				addr_reg_r <= merge(addr_reg_r, wdata_r, wstrb_r);
			if (wr_go && awaddr_r == EPRM_OFS_WDATA)
				wdata_reg_r <= merge(wdata_reg_r, wdata_r, wstrb_r);
			// start while busy is dropped: one operation at a time
			if (wr_go && awaddr_r == EPRM_OFS_CTRL && wstrb_r[0] &&
				wdata_r[EPRM_CTRL_START] && !cmd.busy) begin
				start_r <= 1'b1;
				op_r    <= eprm_op_type'(wdata_r[EPRM_CTRL_OP_LO +: 2]);
			end
		end
	end

	// done is sticky, write one to clear; a new completion wins
	always_ff @(posedge clk) begin
		if (rst)
			done_r <= 1'b0;
		else if (cmd.done)
			done_r <= 1'b1;
		else if (wr_go && awaddr_r == EPRM_OFS_STATUS && wstrb_r[0] &&
			wdata_r[EPRM_ST_DONE])
			done_r <= 1'b0;
	end

	assign cmd.start = start_r;
	assign cmd.op    = op_r;
	assign cmd.addr  = addr_reg_r[EPRM_AW-1:0];
	assign cmd.wdata = wdata_reg_r[EPRM_DW-1:0];

	always_comb begin
		status = EPRM_WORD_ZERO;
		status[EPRM_ST_BUSY] = cmd.busy;
		status[EPRM_ST_DONE] = done_r;
		status[EPRM_ST_FAIL] = cmd.fail;
		status[EPRM_ST_PULSES_LO +: 5] = cmd.pulses;
		rd_hit  = 1'b1;
		rd_word = EPRM_WORD_ZERO;
		case (s_axi_araddr)
			EPRM_OFS_CTRL:   rd_word = {29'h0, op_r, 1'b0};
			EPRM_OFS_ADDR:   rd_word = {14'h0, addr_reg_r[EPRM_AW-1:0]};
			EPRM_OFS_WDATA:  rd_word = {24'h0, wdata_reg_r[EPRM_DW-1:0]};
			EPRM_OFS_STATUS: rd_word = status;
			EPRM_OFS_RDATA:  rd_word = {24'h0, cmd.rdata};
			default:         rd_hit  = 1'b0;
		endcase
	end

	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge clk) begin
		if (rst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= EPRM_WORD_ZERO;
			s_axi_rresp  <= EPRM_RESP_OKAY;
		end else if (s_axi_arvalid && !s_axi_rvalid) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_word;
			s_axi_rresp  <= rd_hit ? EPRM_RESP_OKAY : EPRM_RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule // eprm_axil_regs

/* verif/eprm_host_properties.sv */
// eprm_host_properties: pin sequence checks on the memory controller
module eprm_host_properties
	import eprm_pkg::*;
(
	input wire logic               clk,
	input wire logic               rst,
	input wire logic [EPRM_AW-1:0] address_lines,
	input wire logic [EPRM_DW-1:0] data_lines_out,
	input wire logic               data_lines_oe,
	input wire logic               chip_select_low,
	input wire logic               output_gate_low,
	input wire logic               program_strobe_low,
	input wire logic               program_supply_high,
	input wire logic               identify_high_voltage
);
	logic [10:0] low_cnt_r;
	logic [4:0]  fall_cnt_r;
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	always_ff @(posedge clk) begin
		if (rst || program_strobe_low)
			low_cnt_r <= 11'h000;
		else
			low_cnt_r <= low_cnt_r + 11'h001;
	end
	// pulses since the supply rose; a retry keeps the supply up
	always_ff @(posedge clk) begin
		if (rst || !program_supply_high)
			fall_cnt_r <= 5'h00;
		else if ($fell(program_strobe_low))
			fall_cnt_r <= fall_cnt_r + 5'h01;
	end
	a_pulse_width: assert property ($rose(program_strobe_low) |->
		low_cnt_r == 11'(EPRM_PULSE_CYC))
		else $error("program pulse width wrong");
	a_strobe_mode: assert property (!program_strobe_low |->
		program_supply_high && !chip_select_low && output_gate_low
		&& data_lines_oe)
		else $error("strobe low outside program mode");
	a_program_setup: assert property ($fell(program_strobe_low) |->
		$past(data_lines_oe, 190) && $past(address_lines, 190) == address_lines
		&& $past(data_lines_out, 190) == data_lines_out)
		else $error("address or data not settled before pulse");
	a_supply_lead: assert property ($fell(program_strobe_low) |->
		$past(program_supply_high, 390))
		else $error("supply not raised ahead of pulse");
	a_read_setup: assert property ($fell(output_gate_low) |->
		!$past(chip_select_low, 8) && $past(address_lines, 8) == address_lines)
		else $error("gate fell before select and address settled");
	a_gate_hold: assert property ($fell(output_gate_low) |->
		!output_gate_low [*7])
		else $error("gate released before data valid");
	a_bus_clear: assert property (data_lines_oe |->
		output_gate_low && $past(output_gate_low, 13))
		else $error("host drives data while device may drive");
	a_ident_addr: assert property (identify_high_voltage |->
		address_lines[17:1] == 17'h00000 && !program_supply_high)
		else $error("identify with other lines not low");
	a_pulse_limit: assert property (fall_cnt_r <= EPRM_MAX_PULSES)
		else $error("too many program pulses");
	c_pulse: cover property ($fell(program_strobe_low));
	c_retry_max: cover property (fall_cnt_r == EPRM_MAX_PULSES);
	c_ident: cover property (identify_high_voltage && !output_gate_low);
endmodule // eprm_host_properties

bind eprm_host eprm_host_properties u_props (.*);

/* verif/eprm_dev_model.sv */
// eprm_dev_model: behavioural one-time-programmable memory at the pins
module eprm_dev_model
	import eprm_pkg::*;
#(
	parameter logic [7:0] MAKER_CODE = 8'h15, // arbitrary, odd parity
	parameter logic [7:0] PART_CODE  = 8'h23  // arbitrary, odd parity
)(
	input  wire logic [EPRM_AW-1:0] address_lines,
	input  wire logic [EPRM_DW-1:0] data_lines_in,
	input  wire logic               chip_select_low,
	input  wire logic               output_gate_low,
	input  wire logic               program_strobe_low,
	input  wire logic               program_supply_high,
	input  wire logic               identify_high_voltage,
	output logic      [EPRM_DW-1:0] dev_q,
	output wire logic               dev_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [EPRM_DW-1:0] mem [2**EPRM_AW];
	realtime            t_fall;
	wire                drive;
	initial foreach (mem[i]) mem[i] = 8'hFF;
	assign drive = !chip_select_low && !output_gate_low
		&& (!program_supply_high || program_strobe_low);
	// enable lags the gate, so an early sample sees a floating bus
	assign #(EPRM_GATE_NS) dev_oe = drive;
	always_comb begin
		if (!identify_high_voltage)
			dev_q = mem[address_lines];
		else if (program_supply_high || address_lines[17:1] != 17'h00000)
			dev_q = ~address_lines[7:0];
		else
			dev_q = address_lines[0] ? PART_CODE : MAKER_CODE;
	end
	always @(negedge program_strobe_low) t_fall = $realtime;
	// a short pulse leaves the cell alone; bits only ever clear
	always @(posedge program_strobe_low) begin
		if (program_supply_high && !chip_select_low && output_gate_low
			&& $realtime - t_fall >= EPRM_PULSE_NS)
			mem[address_lines] &= data_lines_in;
	end
endmodule // eprm_dev_model

/* verif/eprm_host_tb_top.sv */
// eprm_host_tb_top: self-checking bench for the memory controller
module eprm_host_tb_top
	import eprm_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {
		logic [31:0] d;
		logic [31:0] m;
		logic [1:0]  r;
	} eprm_exp_type;
	localparam logic [7:0] MAKER = 8'h15; // arbitrary
	localparam logic [7:0] PART  = 8'h23; // arbitrary
	localparam logic [1:0] OK    = EPRM_RESP_OKAY;
	logic               clk = 1'b0, rst = 1'b1;
	logic [7:0]         s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0]        s_axi_wdata = 32'h00000000, s_axi_rdata;
	logic [3:0]         s_axi_wstrb = 4'hF;
	logic               s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
	logic               s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
	logic               s_axi_rready = 1'b0, s_axi_awready, s_axi_wready;
	logic               s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]         s_axi_bresp, s_axi_rresp;
	logic [EPRM_AW-1:0] address_lines;
	logic [7:0]         data_lines_out, data_lines_in, dev_q, dq_hold = 8'h00;
	logic               data_lines_oe, chip_select_low, output_gate_low;
	logic               program_strobe_low, program_supply_high;
	logic               identify_high_voltage;
	wire                dev_oe;
	eprm_exp_type       rq[$];
	logic [1:0]         wq[$];
	int                 n_mismatch = 0, comparisons = 0, seed = 32'h148A7384;
	// a floating bus toggles so an early sample never matches by luck
	assign data_lines_in = data_lines_oe ? data_lines_out
		: dev_oe ? dev_q : ~dq_hold;
	always @(posedge clk) dq_hold <= data_lines_in;
	eprm_host DUT (.*);
	eprm_dev_model #(.MAKER_CODE(MAKER), .PART_CODE(PART)) u_dev (.*);
	initial forever #5 clk = ~clk;
	task automatic cmp32(input string nm, input logic [31:0] e, g);
		comparisons++;
		if (g !== e) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic cmp2(input string nm, input logic [1:0] e, g);
		comparisons++;
		if (g !== e) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	always @(negedge clk) begin
		eprm_exp_type e;
		if (s_axi_rvalid && s_axi_rready) begin
			e = rq.pop_front();
			cmp32("rdata", e.d & e.m, s_axi_rdata & e.m);
			cmp2("rresp", e.r, s_axi_rresp);
		end
		if (s_axi_bvalid && s_axi_bready)
			cmp2("bresp", wq.pop_front(), s_axi_bresp);
	end
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] r);
		logic pa, pw, pb;
		wq.push_back(r);
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		pb = 1'b1;
		while (pb) begin
			@(negedge clk);
			pa = s_axi_awvalid && s_axi_awready;
			pw = s_axi_wvalid && s_axi_wready;
			pb = !(s_axi_bvalid && s_axi_bready);
			@(posedge clk);
			if (pa) s_axi_awvalid <= 1'b0;
			if (pw) s_axi_wvalid <= 1'b0;
			if (!pb) s_axi_bready <= 1'b0;
		end
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] d, m,
		input logic [1:0] r, output logic [31:0] q);
		logic pa, pr;
		rq.push_back('{d, m, r});
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		pr = 1'b1;
		while (pr) begin
			@(negedge clk);
			pa = s_axi_arvalid && s_axi_arready;
			pr = !(s_axi_rvalid && s_axi_rready);
			q = s_axi_rdata;
			@(posedge clk);
			if (pa) s_axi_arvalid <= 1'b0;
			if (!pr) s_axi_rready <= 1'b0;
		end
	endtask
	// one device operation: load, start, poll, check status and byte
	task automatic op(input logic [1:0] o, input logic [17:0] a,
		input logic [7:0] d, input logic [31:0] st, input logic [7:0] e);
		logic [31:0] s, m;
		m = (o == EPRM_OP_PROGRAM) ? 32'h00001F07 : 32'h00000003;
		wr(EPRM_OFS_ADDR, {14'h0000, a}, OK);
		wr(EPRM_OFS_WDATA, {24'h000000, d}, OK);
		wr(EPRM_OFS_CTRL, {29'h00000000, o, 1'b1}, OK);
		rd(EPRM_OFS_CTRL, {29'h00000000, o, 1'b0}, 32'h00000006, OK, s);
		s = 32'h00000000;
		while (s[EPRM_ST_DONE] !== 1'b1)
			rd(EPRM_OFS_STATUS, 32'h00000000, 32'h00000000, OK, s);
		rd(EPRM_OFS_STATUS, st, m, OK, s);
		rd(EPRM_OFS_RDATA, {24'h000000, e}, 32'h000000FF, OK, s);
		wr(EPRM_OFS_STATUS, 32'h00000002, OK);
	endtask
	task automatic test_done;
		if (n_mismatch == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial begin
		logic [31:0] q;
		logic [17:0] a;
		logic [7:0]  d;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		rd(EPRM_OFS_STATUS, 32'h00000000, 32'h00000007, OK, q);
		rd(8'h40, 32'h00000000, 32'h00000000, EPRM_RESP_SLVERR, q);
		wr(8'h40, 32'hFFFFFFFF, EPRM_RESP_SLVERR);
		for (int i = 0; i < 3; i++) begin
			a = 18'($random(seed));
			d = 8'($random(seed)) & 8'hF7;
			op(EPRM_OP_READ, a, 8'h00, 32'h00000002, 8'hFF);
			op(EPRM_OP_PROGRAM, a, d, 32'h00000102, d);
			op(EPRM_OP_READ, a ^ 18'h00001, 8'h00, 32'h00000002, 8'hFF);
			op(EPRM_OP_READ, a, 8'h00, 32'h00000002, d);
		end
		rd(EPRM_OFS_ADDR, {14'h0000, a}, 32'h0003FFFF, OK, q);
		op(EPRM_OP_VERIFY, a, 8'h00, 32'h00000002, d);
		op(EPRM_OP_IDENT, {a[17:1], 1'b0}, 8'h00, 32'h00000002, MAKER);
		op(EPRM_OP_IDENT, {a[17:1], 1'b1}, 8'h00, 32'h00000002, PART);
		op(EPRM_OP_PROGRAM, a, 8'hFF, 32'h00001906, d);
		op(EPRM_OP_READ, a, 8'h00, 32'h00000002, d);
		test_done;
	end
	initial begin
		repeat (90000) @(posedge clk);
		n_mismatch++;
		test_done;
	end
endmodule // eprm_host_tb_top
